// ### verification/adcc_capture_test.sv
// Self-checking bench of the capture controller
// Assumes adcc_far_side plays the sample board and the host port
`timescale 1ns/1ps
`define check_eq(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module adcc_capture_test;
    import adcc_pkg::*;
    localparam int BIT = 16;
    logic ref_clk_i, rstn_i, board_is_adc, strobe_en, strobe, rx, tx;
    logic half_clk, lamp1, lamp2, lamp6;
    logic [1:0] width_sel, count_sel;
    logic [11:0] code;
    logic [17:0] sample_data, first_smp;
    int bad_count = 0, check_count = 0;
    int half_rises = 0, l6_rises = 0, strobe_rises = 0, l1_changes = 0;

    adcc_capture #(.BIT_CYCLES(BIT), .FIFO_DEPTH(4)) adcc_capture_inst (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sample_ready_strobe_i(strobe),
        .sample_data_i(sample_data), .board_is_adc_i(board_is_adc),
        .width_sel_i(width_sel), .count_sel_i(count_sel), .serial_rx_i(rx),
        .serial_tx_o(tx), .half_clk_o(half_clk), .lamp1_o(lamp1),
        .lamp2_o(lamp2), .lamp6_o(lamp6)
    );
    adcc_far_side #(.BIT(BIT)) adcc_far_side_inst (
        .clk_i(ref_clk_i), .strobe_en_i(strobe_en), .code_i(code), .tx_i(tx),
        .strobe_o(strobe), .data_o(sample_data), .rx_o(rx)
    );

    always @(posedge half_clk) half_rises++;
    always @(posedge lamp6) l6_rises++;
    always @(posedge strobe) begin
        strobe_rises++;
        if (strobe_rises == 1) first_smp = sample_data;
    end
    always @(lamp1) l1_changes++;

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================
    // Expectations and helpers
    // Histogram readout byte: one full bin at the inverted-msb code
    function automatic logic [7:0] hist_byte(input int idx);
        logic [23:0] word;
        word = (idx / 3 == int'(code ^ 12'h800)) ? {9'h000, 15'h4000 >> count_sel} : 24'h0;
        return word[8 * (2 - idx % 3) +: 8];
    endfunction : hist_byte

    // Direct record word: low bits kept by the width switches
    function automatic logic [23:0] cap_word(input logic [17:0] d);
        logic [17:0] m;
        m = 18'h3ffff >> (2 * width_sel);
        return {6'h00, board_is_adc ? (d & m) : d};
    endfunction : cap_word

    function automatic logic [7:0] idle_byte();
        logic [7:0] b;
        b = 8'($urandom);
        while (b inside {8'h11, 8'h13, 8'h3f, 8'h44, 8'h48}) b = 8'($urandom);
        return b;
    endfunction : idle_byte

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cycles

    task automatic wait_bytes(input int n);
        for (int i = 0; i < 20000 && adcc_far_side_inst.got_q.size() < n; i++) cycles(1);
        `check_eq(adcc_far_side_inst.got_q.size() >= n, 1'b1)
    endtask : wait_bytes

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        cycles(100000);
        bad_count++;
        complete_run();
    end

    // ==========================================
    // Main sequence
    initial begin
        int n;
        void'($urandom(32'h115a4b61));
        rstn_i = 1'b0;
        board_is_adc = 1'b1;
        width_sel = 2'h3;
        count_sel = 2'h3;
        strobe_en = 1'b0;
        code = 12'h800;
        cycles(8);
        rstn_i <= 1'b1;
        cycles(2);
        `check_eq(lamp1, 1'b1)
        `check_eq(tx, 1'b1)
        adcc_far_side_inst.send_byte(idle_byte());
        adcc_far_side_inst.send_byte(8'h3f);
        cycles(12 * BIT);
        `check_eq(adcc_far_side_inst.got_q.size(), 1)
        `check_eq(adcc_far_side_inst.got_q[0], 8'h4b)
        adcc_far_side_inst.got_q.delete();
        adcc_far_side_inst.send_byte(8'h13);
        adcc_far_side_inst.send_byte(8'h3f);
        cycles(20 * BIT);
        `check_eq(adcc_far_side_inst.got_q.size(), 0)
        adcc_far_side_inst.send_byte(8'h11);
        cycles(12 * BIT);
        `check_eq(adcc_far_side_inst.got_q.size(), 1)
        adcc_far_side_inst.got_q.delete();
        // Half clock and strobe lamp over a burst of strobes
        strobe_rises = 0;
        half_rises = 0;
        l6_rises = 0;
        board_is_adc <= 1'($urandom);
        width_sel <= 2'($urandom);
        count_sel <= 2'($urandom);
        strobe_en <= 1'b1;
        cycles(16 * 20);
        strobe_en <= 1'b0;
        cycles(24);
        `check_eq(half_rises, (strobe_rises + 1) / 2)
        `check_eq(l6_rises, strobe_rises)
        `check_eq(lamp2, 1'b0)
        // Histogram with every sample on one code, random upper bits
        l1_changes = 0;
        board_is_adc <= 1'b1;
        width_sel <= 2'h3;
        count_sel <= 2'h3;
        code <= 12'h800 | 12'($urandom_range(3, 0));
        adcc_far_side_inst.send_byte(8'h48);
        strobe_en <= 1'b1;
        for (int i = 0; i < 90000 && lamp2 !== 1'b1; i++) cycles(1);
        strobe_en <= 1'b0;
        `check_eq(lamp2, 1'b1)
        `check_eq(l1_changes >= 16, 1'b1)
        wait_bytes(3);
        adcc_far_side_inst.send_byte(8'h13);
        cycles(12 * BIT);
        n = adcc_far_side_inst.got_q.size();
        cycles(30 * BIT);
        `check_eq(adcc_far_side_inst.got_q.size(), n)
        adcc_far_side_inst.send_byte(8'h11);
        wait_bytes(n + 6);
        for (int i = 0; i < n + 6; i++) begin
            `check_eq(adcc_far_side_inst.got_q[i], hist_byte(i))
        end
        // Reset in mid readout, then part of a direct record
        rstn_i <= 1'b0;
        cycles(4);
        rstn_i <= 1'b1;
        cycles(2);
        `check_eq(lamp1, 1'b1)
        `check_eq(lamp2, 1'b0)
        `check_eq(half_clk, 1'b0)
        cycles(12 * BIT);
        adcc_far_side_inst.got_q.delete();
        board_is_adc <= 1'($urandom);
        width_sel <= 2'($urandom);
        code <= 12'($urandom);
        adcc_far_side_inst.send_byte(8'h44);
        strobe_rises = 0;
        strobe_en <= 1'b1;
        cycles(64 * BIT);
        strobe_en <= 1'b0;
        cycles(24);
        `check_eq(adcc_capture_inst.addr, 15'(strobe_rises))
        `check_eq(adcc_capture_inst.mem[0], cap_word(first_smp))
        `check_eq(adcc_far_side_inst.got_q.size(), 0)
        `check_eq(lamp2, 1'b0)
        complete_run();
    end
endmodule : adcc_capture_test

// ### verification/adcc_far_side.sv
// Far side of the capture controller: sample board and host serial port
// Assumes clk_i is the system clock; strobe period is sixteen clocks
`timescale 1ns/1ps
module adcc_far_side #(
    parameter int BIT = 16
) (
    input wire logic clk_i,
    input wire logic strobe_en_i,
    input wire logic [11:0] code_i,
    input wire logic tx_i,
    output logic strobe_o,
    output logic [17:0] data_o,
    output logic rx_o
);
    logic [2:0] phase;
    logic [7:0] got_q[$];

    initial begin
        strobe_o = 1'b0;
        data_o = 18'h00000;
        rx_o = 1'b1;
        phase = 3'h0;
    end

    // ==========================================
    // Sample source
    // Data settles mid low phase, steady well past each rise
    always @(posedge clk_i) begin
        if (strobe_en_i || strobe_o) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) begin
                strobe_o <= ~strobe_o;
            end
            if (!strobe_o && phase == 3'h3) begin
                data_o <= {6'($urandom_range(63, 0)), code_i};
            end
        end else begin
            phase <= 3'h0;
            data_o <= ~data_o;
        end
    end

    // ==========================================
    // Host serial port
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rx_o <= f[i];
            repeat (BIT - 1) @(posedge clk_i);
        end
    endtask : send_byte

    always @(negedge tx_i) begin : rx_mon
        logic [7:0] b;
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            b[i] = tx_i;
        end
        repeat (BIT) @(posedge clk_i);
        if (tx_i === 1'b1) begin
            got_q.push_back(b);
        end
    end
endmodule : adcc_far_side

// ### verilog/adcc_capture.sv
// Capture controller: direct record or histogram, returned over serial
// Assumes all pins asynchronous to ref_clk_i; strobe well below 125 MHz
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_capture
    import adcc_pkg::*;
#(
    parameter int BIT_CYCLES = `ADCC_BIT_CYCLES,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sample_ready_strobe_i,
    input wire logic [17:0] sample_data_i,
    input wire logic board_is_adc_i,
    input wire logic [1:0] width_sel_i,
    input wire logic [1:0] count_sel_i,
    input wire logic serial_rx_i,
    output logic serial_tx_o,
    output logic half_clk_o,
    output logic lamp1_o,
    output logic lamp2_o,
    output logic lamp6_o
);
    adcc_state_t state;
    logic [23:0] pin_s1;
    logic [23:0] pin_s2;
    logic strobe_q;
    logic strobe_rise;
    logic [17:0] smp;
    logic is_adc;
    logic [4:0] width;
    logic [14:0] limit;
    logic [14:0] addr;
    logic [23:0] mem [32768];
    logic [23:0] mem_q;
    logic mem_we;
    logic [23:0] mem_wd;
    logic [14:0] next_count;
    logic rd_ok;
    logic [1:0] byte_idx;
    logic ready_lamp;
    logic pending;
    logic xon_en;
    logic rx_valid;
    logic [7:0] rx_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic tx_ready;

    function automatic logic [17:0] adcc_align(input logic [17:0] d, input logic [4:0] w);
        logic [17:0] m;
        m = '0;
        for (int i = 0; i < 18; i++) begin
            m[i] = 5'(i) < w;
        end
        return d & m;
    endfunction : adcc_align

    function automatic logic [14:0] adcc_bin(input logic [17:0] a, input logic [4:0] w);
        logic [17:0] b;
        b = a;
        b[w - 5'h01] = ~b[w - 5'h01];
        b = b >> ((w > `ADCC_BIN_BITS) ? (w - `ADCC_BIN_BITS) : 5'h00);
        return b[14:0];
    endfunction : adcc_bin

    // ========================================
    // Pin synchronisers and strobe edge
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            strobe_q <= 1'b0;
        end else begin
            pin_s1 <= {sample_ready_strobe_i, sample_data_i, board_is_adc_i,
                       width_sel_i, count_sel_i};
            pin_s2 <= pin_s1;
            strobe_q <= pin_s2[23];
        end
    end

    assign strobe_rise = pin_s2[23] & ~strobe_q;
    assign is_adc = pin_s2[4];
    assign width = adcc_width(pin_s2[3:2]);
    assign limit = adcc_limit(pin_s2[1:0]);
    assign smp = is_adc ? adcc_align(pin_s2[22:5], width) : pin_s2[22:5];
    assign next_count = mem_q[14:0] + 15'h0001;

    // ========================================
    // Sample memory
    always_comb begin
        mem_we = 1'b0;
        mem_wd = '0;
        unique case (state)
            ST_CAP: begin
                mem_we = strobe_rise;
                mem_wd = {6'h00, smp};
            end
            ST_CLR: begin
                mem_we = 1'b1;
            end
            ST_HWR: begin
                mem_we = 1'b1;
                mem_wd = {9'h000, next_count};
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[addr] <= mem_wd;
        end
        mem_q <= mem[addr];
    end

    // ========================================
    // Flow control from host
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xon_en <= 1'b1;
        end else if (rx_valid && rx_data == `ADCC_XOFF) begin
            xon_en <= 1'b0;
        end else if (rx_valid && rx_data == `ADCC_XON) begin
            xon_en <= 1'b1;
        end
    end

    // ========================================
    // Capture sequencer
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            addr <= '0;
            rd_ok <= 1'b0;
            byte_idx <= '0;
            ready_lamp <= 1'b1;
            pending <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    addr <= '0;
                    if (!fifo_out_valid && tx_ready) begin
                        pending <= 1'b0;
                    end
                    if (rx_valid && rx_data == `ADCC_CMD_DIRECT) begin
                        state <= ST_CAP;
                        ready_lamp <= 1'b1;
                    end else if (rx_valid && rx_data == `ADCC_CMD_HIST) begin
                        state <= ST_CLR;
                        ready_lamp <= 1'b1;
                    end else if (rx_valid && rx_data == `ADCC_CMD_PING) begin
                        state <= ST_PING;
                    end
                end
                ST_PING: begin
                    if (fifo_in_ready) begin
                        state <= ST_IDLE;
                    end
                end
                ST_CAP: begin
                    if (strobe_rise) begin
                        addr <= addr + 15'h0001;
                        if (addr == `ADCC_LAST_ADDR) begin
                            state <= ST_DUMP;
                            pending <= 1'b1;
                            rd_ok <= 1'b0;
                            byte_idx <= '0;
                        end
                    end
                end
                ST_CLR: begin
                    addr <= addr + 15'h0001;
                    if (addr == `ADCC_LAST_ADDR) begin
                        state <= ST_HWAIT;
                    end
                end
                ST_HWAIT: begin
                    if (strobe_rise) begin
                        addr <= adcc_bin(smp, width);
                        state <= ST_HRD;
                    end
                end
                ST_HRD: begin
                    state <= ST_HWR;
                end
                ST_HWR: begin
                    if (next_count == limit) begin
                        state <= ST_DUMP;
                        addr <= '0;
                        pending <= 1'b1;
                        rd_ok <= 1'b0;
                        byte_idx <= '0;
                    end else begin
                        state <= ST_HWAIT;
                    end
                end
                ST_DUMP: begin
                    rd_ok <= 1'b1;
                    if (rd_ok && fifo_in_ready) begin
                        if (byte_idx == 2'h2) begin
                            byte_idx <= '0;
                            rd_ok <= 1'b0;
                            addr <= addr + 15'h0001;
                            if (addr == `ADCC_LAST_ADDR) begin
                                state <= ST_IDLE;
                                ready_lamp <= 1'b0;
                            end
                        end else begin
                            byte_idx <= byte_idx + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ========================================
    // Readout bytes, most significant first
    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data = `ADCC_PING_REPLY;
        if (state == ST_PING) begin
            fifo_in_valid = 1'b1;
        end else if (state == ST_DUMP) begin
            fifo_in_valid = rd_ok;
            unique case (byte_idx)
                2'h0: fifo_in_data = mem_q[23:16];
                2'h1: fifo_in_data = mem_q[15:8];
                default: fifo_in_data = mem_q[7:0];
            endcase
        end
    end

    // Only XON state gates; modem lines never reach this block
    assign fifo_out_ready = tx_ready & xon_en;

    adcc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    adcc_uart #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_uart (
        .clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .rx_i(serial_rx_i),
        .rx_valid_o(rx_valid),
        .rx_data_o(rx_data),
        .tx_valid_i(fifo_out_valid & xon_en),
        .tx_ready_o(tx_ready),
        .tx_data_i(fifo_out_data),
        .tx_o(serial_tx_o)
    );

    // ========================================
    // Lamps and half-rate clock
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            half_clk_o <= 1'b0;
            lamp1_o <= 1'b0;
            lamp2_o <= 1'b0;
            lamp6_o <= 1'b0;
        end else begin
            if (strobe_rise) begin
                half_clk_o <= ~half_clk_o;
            end
            if (state == ST_IDLE || state == ST_PING) begin
                lamp1_o <= ready_lamp | pending;
            end else begin
                lamp1_o <= addr[`ADCC_LAMP_ADDR_BIT];
            end
            lamp2_o <= pending;
            lamp6_o <= pin_s2[23];
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence hist_update_s;
        state == ST_HRD ##1 state == ST_HWR;
    endsequence

    half_clock_a: assert property (strobe_rise |=> half_clk_o != $past(half_clk_o))
        else $error("half clock did not toggle");
    xoff_pause_a: assert property (rx_valid && rx_data == `ADCC_XOFF |=> !xon_en)
        else $error("xoff ignored");
    xon_resume_a: assert property (rx_valid && rx_data == `ADCC_XON |=> xon_en)
        else $error("xon ignored");
    align_zero_a: assert property (mem_we && state == ST_CAP && is_adc |->
        (mem_wd >> width) == 24'h000000)
        else $error("upper bits not zero");
    width_map_a: assert property (pin_s2[3:2] == 2'h2 |-> width == 5'h0e)
        else $error("width decode wrong");
    limit_map_a: assert property (pin_s2[1:0] == 2'h0 |-> limit == 15'h4000)
        else $error("limit decode wrong");
    hist_stop_a: assert property (state == ST_HWR && next_count == limit |=>
        state == ST_DUMP ##1 state == ST_DUMP)
        else $error("histogram did not stop");
    hist_steps_a: assert property (state == ST_HWAIT && strobe_rise |=> hist_update_s)
        else $error("bin update sequence broken");
    clear_bins_a: assert property (state == ST_CLR |-> mem_we && mem_wd == 24'h000000)
        else $error("bin not cleared");
    record_end_a: assert property (state == ST_CAP && strobe_rise &&
        addr == `ADCC_LAST_ADDR |=> state == ST_DUMP && addr == 15'h0000)
        else $error("record length wrong");
    pending_lamp_a: assert property ($rose(pending) |=> lamp2_o [*2])
        else $error("lamp two not lit");
    flow_gate_a: assert property (!xon_en && tx_ready |=> tx_ready)
        else $error("byte sent while paused");
endmodule : adcc_capture

// ### verilog/adcc_defines.svh
// Constants of the capture controller: offsets, codes, counts
// Assumes inclusion by bare name from the package and modules
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_CLK_HZ 250000000
`define ADCC_BAUD 115200
`define ADCC_BIT_CYCLES (`ADCC_CLK_HZ / `ADCC_BAUD)
`define ADCC_XON 8'h11
`define ADCC_XOFF 8'h13
`define ADCC_CMD_DIRECT 8'h44
`define ADCC_CMD_HIST 8'h48
`define ADCC_CMD_PING 8'h3f
`define ADCC_PING_REPLY 8'h4b
`define ADCC_LAST_ADDR 15'h7fff
`define ADCC_BIN_BITS 5'h0f
`define ADCC_LAMP_ADDR_BIT 10
`define ADCC_W_OFF_OFF 5'h12
`define ADCC_W_OFF_ON 5'h10
`define ADCC_W_ON_OFF 5'h0e
`define ADCC_W_ON_ON 5'h0c
`define ADCC_L_OFF_OFF 15'h4000
`define ADCC_L_OFF_ON 15'h2000
`define ADCC_L_ON_OFF 15'h1000
`define ADCC_L_ON_ON 15'h0800
`endif

// ### verilog/adcc_fifo.sv
// Small synchronous FIFO between memory readout and serial transmitter
// Assumes one clock; depth is a power of two
`timescale 1ns/1ps
module adcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : adcc_fifo

// ### verilog/adcc_pkg.sv
// Types and switch decoders of the capture controller
// Assumes adcc_defines.svh is on the include path
`include "adcc_defines.svh"
package adcc_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_PING = 8'h02,
        ST_CAP = 8'h04,
        ST_CLR = 8'h08,
        ST_HWAIT = 8'h10,
        ST_HRD = 8'h20,
        ST_HWR = 8'h40,
        ST_DUMP = 8'h80
    } adcc_state_t;

    // Bit 1 is the first switch of the pair, bit 0 the second
    function automatic logic [4:0] adcc_width(input logic [1:0] sel);
        unique case (sel)
            2'h0: adcc_width = `ADCC_W_OFF_OFF;
            2'h1: adcc_width = `ADCC_W_OFF_ON;
            2'h2: adcc_width = `ADCC_W_ON_OFF;
            2'h3: adcc_width = `ADCC_W_ON_ON;
        endcase
    endfunction : adcc_width

    function automatic logic [14:0] adcc_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0: adcc_limit = `ADCC_L_OFF_OFF;
            2'h1: adcc_limit = `ADCC_L_OFF_ON;
            2'h2: adcc_limit = `ADCC_L_ON_OFF;
            2'h3: adcc_limit = `ADCC_L_ON_ON;
        endcase
    endfunction : adcc_limit
endpackage : adcc_pkg

// ### verilog/adcc_uart.sv
// 8N1 serial receiver and transmitter for the host link
// Assumes rx_i is an asynchronous pin; tx accepts a byte only when idle
`timescale 1ns/1ps
`include "adcc_defines.svh"
module adcc_uart
    import adcc_pkg::*;
#(
    parameter int BIT_CYCLES = `ADCC_BIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rx_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    output logic tx_o
);
    localparam logic [11:0] BIT_N = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] HALF_N = 12'(BIT_CYCLES / 2 - 1);
    logic rx_s1;
    logic rx_s2;
    logic rx_busy;
    logic [11:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic tx_busy;
    logic [11:0] tx_cnt;
    logic [3:0] tx_left;
    logic [8:0] tx_sh;

    assign tx_ready_o = ~tx_busy;

    // ========================================
    // Receiver, sampled mid-bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_busy <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_sh <= '0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
        end else begin
            rx_s1 <= rx_i;
            rx_s2 <= rx_s1;
            rx_valid_o <= 1'b0;
            if (!rx_busy) begin
                if (!rx_s2) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= HALF_N;
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt != 12'h000) begin
                rx_cnt <= rx_cnt - 12'h001;
            end else begin
                rx_cnt <= BIT_N;
                if (rx_bit == 4'h0) begin
                    rx_busy <= ~rx_s2;
                    rx_bit <= 4'h1;
                end else if (rx_bit != 4'h9) begin
                    rx_sh <= {rx_s2, rx_sh[7:1]};
                    rx_bit <= rx_bit + 4'h1;
                end else begin
                    rx_busy <= 1'b0;
                    rx_valid_o <= rx_s2;
                    rx_data_o <= rx_sh;
                end
            end
        end
    end

    // ========================================
    // Transmitter: start, eight data bits lsb first, one stop
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_busy <= 1'b0;
            tx_cnt <= '0;
            tx_left <= '0;
            tx_sh <= '1;
            tx_o <= 1'b1;
        end else if (!tx_busy) begin
            if (tx_valid_i) begin
                tx_busy <= 1'b1;
                tx_o <= 1'b0;
                tx_sh <= {1'b1, tx_data_i};
                tx_left <= 4'h9;
                tx_cnt <= BIT_N;
            end
        end else if (tx_cnt != 12'h000) begin
            tx_cnt <= tx_cnt - 12'h001;
        end else if (tx_left == 4'h0) begin
            tx_busy <= 1'b0;
        end else begin
            tx_o <= tx_sh[0];
            tx_sh <= {1'b1, tx_sh[8:1]};
            tx_left <= tx_left - 4'h1;
            tx_cnt <= BIT_N;
        end
    end
endmodule : adcc_uart
